//--- crmp_host_model.sv
`timescale 1ns/1ps
// host controller: i2c byte strobes and a slow spi master
module crmp_host_model
  import crmp_pkg::*;
(
  input wire logic       mclk,
  input wire logic [7:0] i2c_rd_data,
  input wire logic       cout_o,
  input wire logic       cout_oe,
  output crmp_req_t      i2c_req,
  output logic           clatch_n,
  output logic           cclk,
  output logic           cin
);
  // idle bus at time zero; serial clock rests low between frames
  initial begin
    i2c_req = '0;
    clatch_n = 1'b1;
    cclk = 1'b0;
    cin = 1'b0;
  end

  // one strobe {start,wr,rd}, held over exactly one taken edge
  task automatic i2c_op(input logic [2:0] k, input logic [7:0] d);
    @(negedge mclk);
    i2c_req = {k, d};
    @(negedge mclk);
    i2c_req = '0;
  endtask : i2c_op

  // byte at current address, then advance
  task automatic i2c_get(output logic [7:0] d);
    repeat (2) @(negedge mclk);
    d = i2c_rd_data;
    i2c_op(3'b001, 8'h00);
  endtask : i2c_get

  // frame of n bytes, o[3] first, msb first; 4 mclk per cclk level
  task automatic spi_frame(input int n, input logic [3:0][7:0] o, output logic [3:0][7:0] r);
    @(negedge mclk);
    clatch_n = 1'b0;
    for (int i = 3; i > 3 - n; i--) begin
      for (int b = 7; b >= 0; b--) begin
        cin = o[i][b];
        repeat (4) @(negedge mclk);
        // released output is seen as floating
        r[i][b] = cout_oe ? cout_o : 1'bz;
        cclk = 1'b1;
        repeat (4) @(negedge mclk);
        cclk = 1'b0;
      end
    end
    repeat (4) @(negedge mclk);
    clatch_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : spi_frame
endmodule : crmp_host_model

//--- crmp_pkg.sv
package crmp_pkg;

  // register count and address width
  localparam int          CRMP_ADDR_W   = 8;
  localparam int          CRMP_DATA_W   = 8;
  localparam int          CRMP_NUM_REGS = 27;

  // register offsets
  localparam logic [7:0]  OFS_MASTER_POWER   = 8'h00;
  localparam logic [7:0]  OFS_CLOCK_MULT     = 8'h01;
  localparam logic [7:0]  OFS_BOOST_CTRL     = 8'h02;
  localparam logic [7:0]  OFS_BIAS_BOOST     = 8'h03;
  localparam logic [7:0]  OFS_BLOCK_POWER    = 8'h04;
  localparam logic [7:0]  OFS_SP_FORMAT      = 8'h05;
  localparam logic [7:0]  OFS_SP_SLOT        = 8'h06;
  localparam logic [7:0]  OFS_CMAP_FIRST     = 8'h07;
  localparam logic [7:0]  OFS_CMAP_SECOND    = 8'h08;
  localparam logic [7:0]  OFS_DRIVE_THERMAL  = 8'h09;
  localparam logic [7:0]  OFS_GAIN_CH1       = 8'h0A;
  localparam logic [7:0]  OFS_GAIN_CH2       = 8'h0B;
  localparam logic [7:0]  OFS_GAIN_CH3       = 8'h0C;
  localparam logic [7:0]  OFS_GAIN_CH4       = 8'h0D;
  localparam logic [7:0]  OFS_SUM_MUTE_CAL   = 8'h0E;
  localparam logic [7:0]  OFS_HOLE           = 8'h0F;
  localparam logic [7:0]  OFS_DIAG_ENABLE    = 8'h10;
  localparam logic [7:0]  OFS_FAULT_CH1      = 8'h11;
  localparam logic [7:0]  OFS_FAULT_CH2      = 8'h12;
  localparam logic [7:0]  OFS_FAULT_CH3      = 8'h13;
  localparam logic [7:0]  OFS_FAULT_CH4      = 8'h14;
  localparam logic [7:0]  OFS_FAULT_IRQ_CFG  = 8'h15;
  localparam logic [7:0]  OFS_FAULT_IRQ_MASK = 8'h16;
  localparam logic [7:0]  OFS_TRIP_ADJUST    = 8'h17;
  localparam logic [7:0]  OFS_TIMEOUT_HYST   = 8'h18;
  localparam logic [7:0]  OFS_CLIP_FLAGS     = 8'h19;
  localparam logic [7:0]  OFS_OFFSET_HPF_CAL = 8'h1A;

  // reset values
  localparam logic [7:0]  RST_MASTER_POWER   = 8'h00;
  localparam logic [7:0]  RST_CLOCK_MULT     = 8'h41;
  localparam logic [7:0]  RST_BOOST_CTRL     = 8'h4A;
  localparam logic [7:0]  RST_BIAS_BOOST     = 8'h7D;
  localparam logic [7:0]  RST_BLOCK_POWER    = 8'h3F;
  localparam logic [7:0]  RST_SP_FORMAT      = 8'h02;
  localparam logic [7:0]  RST_SP_SLOT        = 8'h00;
  localparam logic [7:0]  RST_CMAP_FIRST     = 8'h10;
  localparam logic [7:0]  RST_CMAP_SECOND    = 8'h32;
  localparam logic [7:0]  RST_DRIVE_THERMAL  = 8'hF0;
  localparam logic [7:0]  RST_GAIN           = 8'hA0;
  localparam logic [7:0]  RST_SUM_MUTE_CAL   = 8'h02;
  localparam logic [7:0]  RST_DIAG_ENABLE    = 8'h0F;
  localparam logic [7:0]  RST_FAULT          = 8'h00;
  localparam logic [7:0]  RST_FAULT_IRQ_CFG  = 8'h20;
  localparam logic [7:0]  RST_ZERO           = 8'h00;
  localparam logic [7:0]  RST_TIMEOUT_HYST   = 8'h20;

  // master power field positions
  localparam int          BIT_SOFT_RESET     = 7;
  localparam int          BIT_MASTER_MASTER_POWER_UP    = 0;
  // block power field positions
  localparam int          BIT_LDO_EN         = 5;
  localparam int          BIT_VREF_EN        = 4;
  localparam int          BIT_CONV_EN_LO     = 0;
  // bias/boost field positions
  localparam int          BIT_BIAS_EN        = 3;
  localparam int          BIT_BOOST_EN       = 2;
  // clock multiplier status bit (read only, from outside)
  localparam int          BIT_CLK_LOCK       = 7;
  // boost status bits (read only, from outside)
  localparam int          BIT_BOOST_GOOD     = 7;
  localparam int          BIT_BOOST_OV       = 2;
  localparam int          BIT_BOOST_OC       = 0;

  // spi byte layout: first byte lsb selects direction
  localparam int          BIT_SPI_RW         = 0;
  localparam logic        SPI_DIR_READ       = 1'b1;

  // soft reset hold time, counted in mclk cycles
  localparam int          SRST_HOLD_CYCLES   = 4;

  // port selection
  typedef enum logic [0:0] {
    CRMP_PORT_I2C = 1'b0,
    CRMP_PORT_SPI = 1'b1
  } crmp_port_t;

  // one byte-wide register access from a serial front end
  typedef struct packed {
    logic       start;  // transaction opens: data carries the address byte
    logic       wr;     // write strobe with data
    logic       rd;     // read strobe: fetch current address
    logic [7:0] data;   // address or write data
  } crmp_req_t;

  // power enables steering the analog blocks
  typedef struct packed {
    logic       master_power_up;
    logic       boost_en;
    logic       bias_en;
    logic       vref_en;
    logic       low_dropout_regulator;
    logic [3:0] converter_enable;
  } crmp_pwr_t;

endpackage : crmp_pkg

//--- crmp_regbank.sv
`timescale 1ns/1ps
// Functional notes
// (RQ1) registers reachable through either control port
// (RQ2) master power drives block power enables
// (RQ3) soft reset bit restores every register default
// (RQ4) host may skip soft reset at power cycles
// (RQ5) bit 0 gates full power up/down
// (RQ6) block enables still gate individual blocks
// (RQ7) block power resets 0x3F, converters enabled
// (RQ8) spi first byte lsb: 1 read
// (RQ9) address advances after every data byte
// (RQ10) soft reset bit self-clears when done
module crmp_regbank
  import crmp_pkg::*;
#(
  parameter int SRST_CYCLES = SRST_HOLD_CYCLES  // soft reset length in mclk cycles
)
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  // i2c byte-level requests from the i2c engine
  input  crmp_req_t       i2c_req,
  output logic [7:0]      i2c_rd_data,
  // spi pins, active after three dummy frames
  input  wire logic       clatch_n,
  input  wire logic       cclk,
  input  wire logic       cin,
  output logic            cout_o,
  output logic            cout_oe,
  // read-only status from the analog side
  input  wire logic       clk_locked,
  input  wire logic       boost_good,
  input  wire logic       boost_overvolt,
  input  wire logic       boost_overcurr,
  // power enables and soft reset indication
  output crmp_pwr_t       pwr,
  output logic            soft_reset_active,
  output logic            spi_selected
);

  logic [7:0]    regs_r [CRMP_NUM_REGS];  // register storage, by offset
  logic [7:0]    addr_r;                  // current register address
  logic [1:0]    latch_cnt_r;             // dummy frames seen on clatch
  logic          clatch_d_r;              // clatch history for rising edge
  logic          spi_mode_r;              // sticky spi selection
  logic [3:0]    srst_cnt_r;              // soft reset countdown
  crmp_req_t     spi_req;                 // requests from spi front end
  crmp_req_t     cur_req;                 // request of the active port
  logic [7:0]    rd_byte;                 // read value at addr_r
  logic          srst_req;                // write of 1 into soft reset bit
  crmp_pwr_t     pwr_nxt;

  // reset value per offset; holes and reserved read zero
  function automatic logic [7:0] reset_val(input logic [7:0] ofs);
    logic [7:0] v;
    v = RST_ZERO;
    if (ofs == OFS_CLOCK_MULT) begin
      v = RST_CLOCK_MULT;
    end else if (ofs == OFS_BOOST_CTRL) begin
      v = RST_BOOST_CTRL;
    end else if (ofs == OFS_BIAS_BOOST) begin
      v = RST_BIAS_BOOST;
    end else if (ofs == OFS_BLOCK_POWER) begin
      v = RST_BLOCK_POWER; // RQ7
    end else if (ofs == OFS_SP_FORMAT) begin
      v = RST_SP_FORMAT;
    end else if (ofs == OFS_CMAP_FIRST) begin
      v = RST_CMAP_FIRST;
    end else if (ofs == OFS_CMAP_SECOND) begin
      v = RST_CMAP_SECOND;
    end else if (ofs == OFS_DRIVE_THERMAL) begin
      v = RST_DRIVE_THERMAL;
    end else if (ofs >= OFS_GAIN_CH1 && ofs <= OFS_GAIN_CH4) begin
      v = RST_GAIN;
    end else if (ofs == OFS_SUM_MUTE_CAL) begin
      v = RST_SUM_MUTE_CAL;
    end else if (ofs == OFS_DIAG_ENABLE) begin
      v = RST_DIAG_ENABLE;
    end else if (ofs == OFS_FAULT_IRQ_CFG) begin
      v = RST_FAULT_IRQ_CFG;
    end else if (ofs == OFS_TIMEOUT_HYST) begin
      v = RST_TIMEOUT_HYST;
    end
    return v;
  endfunction : reset_val

  // mapped offsets: 0x00..0x0E and 0x10..0x1A
  function automatic logic mapped(input logic [7:0] ofs);
    return (ofs <= OFS_OFFSET_HPF_CAL) && (ofs != OFS_HOLE);
  endfunction : mapped

  // spi front end shares the same register path
  crmp_spi_front u_spi (
    .mclk     (mclk),
    .resetn   (resetn),
    .spi_mode (spi_mode_r),
    .clatch_n (clatch_n),
    .cclk     (cclk),
    .cin      (cin),
    .rd_data  (rd_byte),
    .req      (spi_req),
    .cout_o   (cout_o),
    .cout_oe  (cout_oe)
  );

  // port selection: three clatch pulses switch to spi for good
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clatch_d_r  <= 1'b1;
      latch_cnt_r <= 2'h0;
      spi_mode_r  <= 1'b0;
    end else begin
      clatch_d_r <= clatch_n;
      // only power cycling leaves spi mode, so soft reset keeps it
      if (!spi_mode_r && clatch_n && !clatch_d_r) begin
        if (latch_cnt_r == 2'h2) begin
          spi_mode_r <= 1'b1;
        end
        latch_cnt_r <= latch_cnt_r + 2'h1;
      end
    end
  end

  // active port picks the request stream
  assign cur_req = spi_mode_r ? spi_req : i2c_req; // RQ1

  // read mux with live status bits merged in
  always_comb begin
    rd_byte = 8'h00;
    if (mapped(addr_r)) begin
      rd_byte = regs_r[addr_r[4:0]];
      if (addr_r == OFS_CLOCK_MULT) begin
        rd_byte[BIT_CLK_LOCK] = clk_locked;
      end else if (addr_r == OFS_BOOST_CTRL) begin
        rd_byte[BIT_BOOST_GOOD] = boost_good;
        rd_byte[BIT_BOOST_OV]   = boost_overvolt;
        rd_byte[BIT_BOOST_OC]   = boost_overcurr;
      end
    end
  end

  // registered read byte for the i2c engine
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      i2c_rd_data <= 8'h00;
    end else begin
      i2c_rd_data <= rd_byte;
    end
  end

  assign srst_req = cur_req.wr && addr_r == OFS_MASTER_POWER && cur_req.data[BIT_SOFT_RESET];

  // address pointer: loaded at start, bumped after each byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= 8'h00;
    end else if (cur_req.start) begin
      addr_r <= cur_req.data;
    end else if (cur_req.wr || cur_req.rd) begin
      addr_r <= addr_r + 8'h01; // RQ9
    end
  end

  // soft reset sequencer: hold internal reset then release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srst_cnt_r <= 4'h0;
    end else if (srst_req) begin
      srst_cnt_r <= 4'(SRST_CYCLES); // RQ3
    end else if (srst_cnt_r != 4'h0) begin
      srst_cnt_r <= srst_cnt_r - 4'h1; // RQ10
    end
  end

  // register storage; soft reset restores defaults every cycle it runs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CRMP_NUM_REGS; i++) begin
        regs_r[i] <= reset_val(8'(i));
      end
    end else if (srst_req || srst_cnt_r != 4'h0) begin
      // defaults include soft reset bit at 0: it reads back cleared
      for (int i = 0; i < CRMP_NUM_REGS; i++) begin
        regs_r[i] <= reset_val(8'(i)); // RQ3 RQ10
      end
    end else if (cur_req.wr && mapped(addr_r)) begin
      regs_r[addr_r[4:0]] <= cur_req.data; // RQ1
    end
  end

  // power enables: master bit gates, block bits still switch blocks off
  always_comb begin
    pwr_nxt                       = '0;
    pwr_nxt.master_power_up       = regs_r[OFS_MASTER_POWER[4:0]][BIT_MASTER_MASTER_POWER_UP]; // RQ5
    if (pwr_nxt.master_power_up) begin
      pwr_nxt.boost_en              = regs_r[OFS_BIAS_BOOST[4:0]][BIT_BOOST_EN]; // RQ2 RQ6
      pwr_nxt.bias_en               = regs_r[OFS_BIAS_BOOST[4:0]][BIT_BIAS_EN]; // RQ6
      pwr_nxt.vref_en               = regs_r[OFS_BLOCK_POWER[4:0]][BIT_VREF_EN]; // RQ6
      pwr_nxt.low_dropout_regulator = regs_r[OFS_BLOCK_POWER[4:0]][BIT_LDO_EN]; // RQ6
      pwr_nxt.converter_enable      = regs_r[OFS_BLOCK_POWER[4:0]][BIT_CONV_EN_LO +: 4]; // RQ7
    end
    if (srst_req || srst_cnt_r != 4'h0) begin
      // also in the request cycle, so no enable leaks out as the reset starts
      pwr_nxt = '0; // RQ3
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwr               <= '0;
      soft_reset_active <= 1'b0;
      spi_selected      <= 1'b0;
    end else begin
      pwr               <= pwr_nxt;
      soft_reset_active <= srst_req || srst_cnt_r > 4'h1;
      spi_selected      <= spi_mode_r;
    end
  end

endmodule : crmp_regbank

//--- crmp_regbank_sva.sv
`timescale 1ns/1ps
// port-level watcher of the register bank
module crmp_regbank_sva
  import crmp_pkg::*;
#(
  parameter int SRST_CYCLES = SRST_HOLD_CYCLES
)
(
  input wire logic       mclk,
  input wire logic       resetn,
  input crmp_req_t       i2c_req,
  input wire logic [7:0] i2c_rd_data,
  input wire logic       clatch_n,
  input wire logic       cclk,
  input wire logic       cin,
  input wire logic       cout_o,
  input wire logic       cout_oe,
  input wire logic       clk_locked,
  input wire logic       boost_good,
  input wire logic       boost_overvolt,
  input wire logic       boost_overcurr,
  input crmp_pwr_t       pwr,
  input wire logic       soft_reset_active,
  input wire logic       spi_selected
);
  logic [7:0] adr_r;    // shadow of the access address
  logic       adv_r;    // shadow trusted since last start
  logic [3:0] sr_cnt_r; // cycles spent in soft reset

  // shadow address; dropped whenever the bank may lose its own
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      adr_r <= 8'h00;
      adv_r <= 1'b0;
    end else if (soft_reset_active || spi_selected) begin
      adv_r <= 1'b0;
    end else if (i2c_req.start) begin
      adr_r <= i2c_req.data;
      adv_r <= 1'b1;
    end else if (i2c_req.wr || i2c_req.rd) begin
      adr_r <= adr_r + 8'h01;
    end
  end

  // soft reset length counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sr_cnt_r <= 4'h0;
    end else if (soft_reset_active) begin
      sr_cnt_r <= sr_cnt_r + 4'h1;
    end else begin
      sr_cnt_r <= 4'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // address held over two samples, so the registered byte is settled
  sequence s_held(logic [7:0] a);
    adv_r && $past(adv_r) && adr_r == a && $past(adr_r) == a;
  endsequence

  a_pwr_gated: assert property (!pwr.master_power_up |-> pwr[7:0] == 8'h00)
    else $error("block enable on while master power is off");
  a_srst_pwr_off: assert property (soft_reset_active |-> pwr == 9'h000)
    else $error("power enable on during soft reset");
  a_srst_start: assert property (adv_r && adr_r == OFS_MASTER_POWER && i2c_req.wr && i2c_req.data[7]
    |-> ##[0:2] soft_reset_active)
    else $error("soft reset write did not start a reset");
  a_srst_bounded: assert property (sr_cnt_r <= SRST_CYCLES + 1)
    else $error("soft reset did not clear by itself");
  a_oe_idle: assert property (clatch_n && $past(clatch_n) |-> !cout_oe)
    else $error("serial out driven outside a frame");
  a_spi_sticky: assert property (spi_selected |=> spi_selected)
    else $error("spi mode dropped without full reset");
  a_lock_read: assert property (s_held(OFS_CLOCK_MULT) ##0 $stable(clk_locked)
    |-> i2c_rd_data[BIT_CLK_LOCK] == clk_locked)
    else $error("lock status not shown in read");
  a_hole_read: assert property (s_held(OFS_HOLE) |-> i2c_rd_data == 8'h00)
    else $error("unmapped address read non zero");

  c_soft_reset: cover property ($rose(soft_reset_active));
  c_spi_mode: cover property ($rose(spi_selected));
  c_spi_read: cover property (cout_oe && !clatch_n);
endmodule : crmp_regbank_sva

bind crmp_regbank crmp_regbank_sva #(.SRST_CYCLES(SRST_CYCLES)) sva_u (
  .mclk(mclk), .resetn(resetn), .i2c_req(i2c_req), .i2c_rd_data(i2c_rd_data),
  .clatch_n(clatch_n), .cclk(cclk), .cin(cin), .cout_o(cout_o), .cout_oe(cout_oe),
  .clk_locked(clk_locked), .boost_good(boost_good), .boost_overvolt(boost_overvolt),
  .boost_overcurr(boost_overcurr), .pwr(pwr), .soft_reset_active(soft_reset_active),
  .spi_selected(spi_selected));

//--- crmp_spi_front.sv
`timescale 1ns/1ps
// serial control port front end: turns spi bytes into register requests
module crmp_spi_front
  import crmp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       spi_mode,      // spi port has been selected
  input  wire logic       clatch_n,      // chip select, low during a frame
  input  wire logic       cclk,          // serial clock, sampled on mclk
  input  wire logic       cin,           // serial data in, msb first
  input  wire logic [7:0] rd_data,       // register byte at current address
  output crmp_req_t       req,           // request toward the register bank
  output logic            cout_o,        // serial data out
  output logic            cout_oe        // high while driving cout
);

  logic       cclk_d_r;        // previous cclk sample for edge detect
  logic [2:0] bit_cnt_r;       // bit position within byte
  logic [7:0] shift_r;         // incoming shift register
  logic [1:0] byte_idx_r;      // 0 dev/rw, 1 addr, 2+ data
  logic       is_read_r;       // direction from first byte
  logic [7:0] out_sh_r;        // outgoing shift register
  logic       out_en_r;        // drive cout during read data
  logic       fetch_pend_r;    // first read fetch, owed one cycle after address load
  logic [7:0] byte_in;         // completed byte
  logic       rise;
  logic       fall;
  logic       active;

  assign active  = spi_mode && !clatch_n;
  assign rise    = active && cclk && !cclk_d_r;
  assign fall    = active && !cclk && cclk_d_r;
  assign byte_in = {shift_r[6:0], cin};

  // cclk edge detect
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cclk_d_r <= 1'b0;
    end else begin
      cclk_d_r <= cclk;
    end
  end

  // input shifting and byte framing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r  <= 3'h0;
      shift_r    <= 8'h00;
      byte_idx_r <= 2'h0;
      is_read_r  <= 1'b0;
    end else if (!active) begin
      // frame closed: restart framing
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= 2'h0;
    end else if (rise) begin
      shift_r   <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        if (byte_idx_r == 2'h0) begin
          is_read_r <= (byte_in[BIT_SPI_RW] == SPI_DIR_READ); // RQ8
        end
        if (byte_idx_r != 2'h2) begin
          byte_idx_r <= byte_idx_r + 2'h1;
        end
      end
    end
  end

  // request strobes, one mclk cycle each
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req          <= '0;
      fetch_pend_r <= 1'b0;
    end else begin
      req.start <= rise && bit_cnt_r == 3'h7 && byte_idx_r == 2'h1;
      req.wr    <= rise && bit_cnt_r == 3'h7 && byte_idx_r == 2'h2 && !is_read_r;
      // first fetch trails the address load: sharing its cycle would read the old address
      fetch_pend_r <= rise && bit_cnt_r == 3'h7 && byte_idx_r == 2'h1 && is_read_r; // RQ8
      // later fetches right after the previous data byte ends
      req.rd    <= (rise && bit_cnt_r == 3'h7 && byte_idx_r == 2'h2 && is_read_r) || fetch_pend_r; // RQ9
      req.data  <= byte_in;
    end
  end

  // output shifting on falling cclk; load after each fetch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_sh_r <= 8'h00;
      out_en_r <= 1'b0;
    end else if (!active) begin
      out_en_r <= 1'b0;
    end else if (req.rd) begin
      out_sh_r <= rd_data;
      out_en_r <= 1'b1;
    end else if (fall && out_en_r && bit_cnt_r != 3'h0) begin
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
  end

  assign cout_o  = out_sh_r[7];
  assign cout_oe = out_en_r;

endmodule : crmp_spi_front

//--- tb.sv
`timescale 1ns/1ps
// self-checking bench for the register bank
module tb;
  import crmp_pkg::*;
  logic             mclk, resetn, cout_o, cout_oe, soft_reset_active, spi_selected;
  logic             clatch_n, cclk, cin, clk_locked, boost_good, boost_overvolt, boost_overcurr;
  logic [7:0]       i2c_rd_data, d;
  logic [3:0][7:0]  r;
  crmp_req_t        i2c_req;
  crmp_pwr_t        pwr;
  int               bad_count, n_compared;
  // expected reset image, unmapped places read 0
  localparam logic [7:0] DEF [28] = '{8'h00, 8'h41, 8'h4A, 8'h7D, 8'h3F, 8'h02, 8'h00, 8'h10, 8'h32, 8'hF0,
    8'hA0, 8'hA0, 8'hA0, 8'hA0, 8'h02, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h20,
    8'h00, 8'h00, 8'h00};

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  crmp_regbank #(.SRST_CYCLES(4)) dut_u (.mclk(mclk), .resetn(resetn), .i2c_req(i2c_req),
    .i2c_rd_data(i2c_rd_data), .clatch_n(clatch_n), .cclk(cclk), .cin(cin), .cout_o(cout_o),
    .cout_oe(cout_oe), .clk_locked(clk_locked), .boost_good(boost_good), .boost_overvolt(boost_overvolt),
    .boost_overcurr(boost_overcurr), .pwr(pwr), .soft_reset_active(soft_reset_active),
    .spi_selected(spi_selected));
  crmp_host_model host_u (.mclk(mclk), .i2c_rd_data(i2c_rd_data), .cout_o(cout_o), .cout_oe(cout_oe),
    .i2c_req(i2c_req), .clatch_n(clatch_n), .cclk(cclk), .cin(cin));

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d, unexpected %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // every address from 0x00 to 0x1B after power-on reset
  task automatic t_defaults();
    check("pwr at reset", pwr, 9'h000);
    host_u.i2c_op(3'b100, 8'h00);
    for (int a = 0; a < 28; a++) begin
      host_u.i2c_get(d);
      check("reset value", d, DEF[a]);
    end
    $display("end defaults");
  endtask : t_defaults

  // burst write 0x01..0x1B; hole and past-end stay 0, status bits read live
  task automatic t_rw();
    host_u.i2c_op(3'b100, 8'h01);
    for (int a = 1; a < 28; a++) host_u.i2c_op(3'b010, 8'hC3 ^ 8'(a));
    host_u.i2c_op(3'b100, 8'h01);
    for (int a = 1; a < 28; a++) begin
      host_u.i2c_get(d);
      check("readback", d, (a == 15 || a == 27) ? 8'h00 : (8'hC3 ^ 8'(a)) & (a == 1 ? 8'h7F :
        a == 2 ? 8'h7A : 8'hFF));
    end
    $display("end readback");
  endtask : t_rw

  // read-only status overlays
  task automatic t_status();
    clk_locked = 1'b1;
    boost_good = 1'b1;
    boost_overvolt = 1'b1;
    host_u.i2c_op(3'b100, 8'h01);
    host_u.i2c_get(d);
    check("lock bit", d[7], 1'b1);
    host_u.i2c_get(d);
    check("boost status", {d[7], d[2], d[0]}, 3'b110);
    clk_locked = 1'b0;
    boost_overvolt = 1'b0;
    boost_overcurr = 1'b1;
    host_u.i2c_op(3'b100, 8'h02);
    host_u.i2c_get(d);
    check("boost status", {d[7], d[2], d[0]}, 3'b101);
    boost_good = 1'b0;
    boost_overcurr = 1'b0;
    $display("end status");
  endtask : t_status

  // block enables only count once master power is up; no soft reset needed
  task automatic t_power();
    host_u.i2c_op(3'b100, 8'h03);
    host_u.i2c_op(3'b010, 8'h0C);
    host_u.i2c_op(3'b010, 8'h35);
    repeat (3) @(negedge mclk);
    check("pwr master off", pwr, 9'h000);
    host_u.i2c_op(3'b100, 8'h00);
    host_u.i2c_op(3'b010, 8'h01);
    repeat (3) @(negedge mclk);
    check("pwr master on", pwr, 9'h1F5);
    host_u.i2c_op(3'b100, 8'h00);
    host_u.i2c_op(3'b010, 8'h00);
    repeat (3) @(negedge mclk);
    check("pwr powered down", pwr, 9'h000);
    $display("end power");
  endtask : t_power

  // soft reset while powered: defaults back, bit clears itself
  task automatic t_soft();
    host_u.i2c_op(3'b100, 8'h00);
    host_u.i2c_op(3'b010, 8'h01);
    repeat (3) @(negedge mclk);
    check("pwr before reset", pwr, 9'h1F5);
    host_u.i2c_op(3'b100, 8'h00);
    host_u.i2c_op(3'b010, 8'h81);
    check("soft reset running", soft_reset_active, 1'b1);
    check("pwr in soft reset", pwr, 9'h000);
    repeat (12) @(negedge mclk);
    check("soft reset level", soft_reset_active, 1'b0);
    check("pwr after reset", pwr, 9'h000);
    host_u.i2c_op(3'b100, 8'h00);
    for (int a = 0; a < 5; a++) begin
      host_u.i2c_get(d);
      check("after soft reset", d, DEF[a]);
    end
    $display("end soft reset");
  endtask : t_soft

  // three dummy frames, burst write, ignored i2c write, burst read
  task automatic t_spi();
    for (int f = 0; f < 3; f++) begin
      check("spi mode", spi_selected, 1'b0);
      host_u.spi_frame(1, 32'h0, r);
    end
    check("spi mode", spi_selected, 1'b1);
    host_u.spi_frame(4, 32'h00075AA5, r);
    host_u.i2c_op(3'b100, 8'h07);
    host_u.i2c_op(3'b010, 8'hFF);
    host_u.spi_frame(4, 32'h01070000, r);
    check("spi read first", r[1], 8'h5A);
    check("spi read next", r[0], 8'hA5);
    $display("end spi");
  endtask : t_spi

  // main sequence; inputs change on falling edges
  initial begin
    resetn = 1'b0;
    clk_locked = 1'b0;
    boost_good = 1'b0;
    boost_overvolt = 1'b0;
    boost_overcurr = 1'b0;
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    t_defaults();
    t_rw();
    t_status();
    t_power();
    t_soft();
    t_spi();
    conclude();
  end

  // watchdog, about eighteen times the expected run
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule : tb
